// ---- bench/test_supervision_timer.sv ----
/*
 * self-checking bench for the supervision timer: register access, timeout
 * decode, periodic ticks, both shutdown paths and restart of the count.
 * assumes the design package is compiled first; a second is cut to 4 cycles.
 */
`timescale 1ns/1ps

module test_supervision_timer;
    // ==========================================================
    // signals and constants
    localparam int CPS = 4;    // short second keeps the 100 s case at 400 cycles
    localparam int SECS [8] = '{0, 5, 10, 20, 40, 60, 80, 100};
    localparam logic [11:0] CTRL   = supervision_timer_pkg::CTRL_ADDR;
    localparam logic [11:0] STATUS = supervision_timer_pkg::STATUS_ADDR;
    localparam logic [11:0] CLEAR  = supervision_timer_pkg::CLEAR_ADDR;
    localparam logic [11:0] ENABLE = supervision_timer_pkg::ENABLE_ADDR;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic [2:0]  boot_timeout_select = 3'h5;
    logic        ext_irq_pending = 1'b0;
    logic        irq;
    logic        supervision_timer_shutdown;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;

    supervision_timer #(.CYCLES_PER_SECOND(32'(CPS))) i_supervision_timer (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .boot_timeout_select,
        .ext_irq_pending, .irq, .supervision_timer_shutdown);

    // ==========================================================
    // clock and a free cycle count used to time events
    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // ==========================================================
    // reporting
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    task automatic chk_flag(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
            n_errors++;
        end
    endtask

    // a wait that runs out of its bound ends the run
    task automatic give_up();
        n_errors++;
        $display("MISMATCH wait expected done seen timeout");
        end_sim();
    endtask

    // ==========================================================
    // bus cycles: payload held until each channel's own ready
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge clk);
            if (s_axi_bvalid) begin
                chk_word("bresp", 32'(supervision_timer_pkg::RESP_OKAY), 32'(s_axi_bresp));
                s_axi_bready <= 1'b0;
                break;
            end
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (k == 64) give_up();
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge clk);
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (k == 64) give_up();
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk_word(nm, e, d);
    endtask

    // clear status bits and let the registered irq settle
    task automatic clr(input logic [31:0] v);
        wr(CLEAR, v);
        repeat (2) @(posedge clk);
    endtask

    // sel 0 waits for irq, sel 1 for shutdown; t is the cycle it was seen high
    task automatic wait_hi(input int lim, input bit sel, output int t);
        int k;
        for (k = 0; k < lim; k++) begin
            @(posedge clk);
            if ((sel ? supervision_timer_shutdown : irq) === 1'b1) break;
        end
        t = cyc;
        if (k == lim) give_up();
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);    // boot value lands at the third edge
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk(CTRL, 32'h05, "ctrl boot");
        wr(CTRL, 32'hfa);
        rd_chk(CTRL, 32'h0a, "ctrl rewrite");
        rd_chk(ENABLE, 32'h0, "enable reset");
        wr(ENABLE, 32'hff);
        rd_chk(ENABLE, 32'h3, "enable rw");
        rd_chk(CLEAR, 32'h0, "clear reads");
        rd(12'h010, d, r);
        chk_word("unmapped resp", 32'(supervision_timer_pkg::RESP_SLVERR), 32'(r));
    endtask

    // every nonzero code: exact spacing of two consecutive cleared ticks
    task automatic t_decode();
        int t0;
        int t1;
        for (int s = 1; s < 8; s++) begin
            wr(CTRL, 32'(s));
            clr(32'h3);
            wait_hi(SECS[s] * CPS + 20, 1'b0, t0);
            clr(32'h1);
            wait_hi(SECS[s] * CPS + 20, 1'b0, t1);
            chk_word("period", 32'(SECS[s] * CPS), 32'(t1 - t0));
            clr(32'h1);
        end
        chk_flag("no shutdown when cleared", 1'b0, supervision_timer_shutdown);
    endtask

    // masked tick stays in status without raising irq
    task automatic t_mask();
        wr(CTRL, 32'h02);
        wr(ENABLE, 32'h0);
        clr(32'h3);
        repeat (44) @(posedge clk);
        chk_flag("masked irq", 1'b0, irq);
        rd_chk(STATUS, 32'h1, "tick status");
        wr(ENABLE, 32'h1);
        repeat (2) @(posedge clk);
        chk_flag("enabled irq", 1'b1, irq);
        clr(32'h1);
        chk_flag("cleared irq", 1'b0, irq);
    endtask

    task automatic t_restart();
        int t0;
        int tw;
        wr(CTRL, 32'h01);
        clr(32'h3);
        wait_hi(40, 1'b0, t0);
        clr(32'h1);
        repeat (6) @(posedge clk);
        wr(CTRL, 32'h01);
        tw = cyc;
        wait_hi(40, 1'b0, t0);
        chk_flag("count restart", 1'b1, (t0 - tw >= 17) && (t0 - tw <= 23));
        clr(32'h1);
    endtask

    // code zero in both behaviours, with another interrupt pending throughout
    task automatic t_disabled();
        ext_irq_pending <= 1'b1;
        foreach (SECS[i]) begin
            if (i > 1) break;
            wr(CTRL, i == 0 ? 32'h00 : 32'h08);
            clr(32'h3);
            repeat (450) @(posedge clk);
            rd_chk(STATUS, 32'h0, "status while off");
            chk_flag("shutdown while off", 1'b0, supervision_timer_shutdown);
        end
        ext_irq_pending <= 1'b0;
    endtask

    task automatic t_missed();
        int t0;
        int t1;
        wr(CTRL, 32'h01);
        clr(32'h3);
        wait_hi(40, 1'b0, t0);
        wait_hi(40, 1'b1, t1);
        chk_flag("missed clear delay", 1'b1, (t1 - t0 >= 19) && (t1 - t0 <= 21));
        rd_chk(STATUS, 32'h3, "status after shutdown");
        clr(32'h3);
        chk_flag("shutdown sticky", 1'b1, supervision_timer_shutdown);
        boot_timeout_select <= 3'h3;
        do_reset();
        chk_flag("shutdown after reset", 1'b0, supervision_timer_shutdown);
        rd_chk(CTRL, 32'h03, "ctrl second boot");
    endtask

    task automatic t_irq_mode();
        int t0;
        int t1;
        wr(CTRL, 32'h09);
        ext_irq_pending <= 1'b1;
        repeat (15) @(posedge clk);
        ext_irq_pending <= 1'b0;
        repeat (40) @(posedge clk);
        chk_flag("short pending", 1'b0, supervision_timer_shutdown);
        ext_irq_pending <= 1'b1;
        t0 = cyc;
        wait_hi(40, 1'b1, t1);
        chk_flag("pending too long", 1'b1, (t1 - t0 >= 19) && (t1 - t0 <= 23));
        ext_irq_pending <= 1'b0;
        do_reset();
    endtask

    // ==========================================================
    // main sequence
    initial begin
        do_reset();
        t_regs();
        t_decode();
        t_mask();
        t_restart();
        t_disabled();
        t_missed();
        t_irq_mode();
        end_sim();
    end
endmodule

// ---- src/supervision_timer.sv ----
/*
 * supervision timer with axi4-lite register access, sticky event status,
 * interrupt enable and a latched shutdown request.
 * assumes: single clock, ext_irq_pending comes from logic on clk,
 * boot_timeout_select is a static strap from boot configuration.
 */
`timescale 1ns/1ps

module supervision_timer #(
    parameter logic [31:0] CYCLES_PER_SECOND = supervision_timer_pkg::CYCLES_PER_SECOND
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  boot_timeout_select,
    input  wire logic        ext_irq_pending,
    output logic             irq,
    output logic             supervision_timer_shutdown
);

    // ==========================================================
    // state
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_have;
        logic [11:0] awaddr;
        logic        w_have;
        logic [7:0]  wdata;
        logic        wstrb0;
        logic        mode;
        logic [2:0]  sel;
        logic [2:0]  boot_s1;
        logic [2:0]  boot_s2;
        logic [1:0]  boot_cnt;
        logic [31:0] presc;
        logic [6:0]  sec;
        logic [1:0]  status;
        logic [1:0]  enable;
        logic        irq;
        logic        shutdown;
    } state_s;

    state_s st_reg;
    state_s st_next;

    logic       boot_done;
    logic       do_write;
    logic       cfg_wr;
    logic [1:0] clr_mask;
    logic [1:0] ev_set;
    logic       counting;
    logic       expire;
    logic [6:0] limit;

    assign boot_done = (st_reg.boot_cnt == supervision_timer_pkg::BOOT_WAIT);
    assign limit     = supervision_timer_pkg::timeout_secs(st_reg.sel);

    // ==========================================================
    // next-state logic
    always_comb begin
        st_next  = st_reg;
        cfg_wr   = 1'b0;
        clr_mask = 2'h0;
        ev_set   = 2'h0;
        expire   = 1'b0;
        do_write = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;

        // write address and data are taken independently, in either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_have = 1'b1;
            st_next.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_have = 1'b1;
            st_next.wdata  = s_axi_wdata[7:0];
            st_next.wstrb0 = s_axi_wstrb[0];
        end

        // perform the write once both halves are held
        if (do_write) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = supervision_timer_pkg::RESP_OKAY;
            unique case (st_reg.awaddr)
                supervision_timer_pkg::CTRL_ADDR: begin
                    if (st_reg.wstrb0) begin
                        cfg_wr = 1'b1;
                    end
                end
                supervision_timer_pkg::CLEAR_ADDR: begin
                    if (st_reg.wstrb0) begin
                        clr_mask = st_reg.wdata[1:0];
                    end
                end
                supervision_timer_pkg::ENABLE_ADDR: begin
                    if (st_reg.wstrb0) begin
                        st_next.enable = st_reg.wdata[1:0];
                    end
                end
                supervision_timer_pkg::STATUS_ADDR: begin
                    st_next.bresp = supervision_timer_pkg::RESP_OKAY;
                end
                default: begin
                    st_next.bresp = supervision_timer_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // one write at a time: no new address or data until the response is gone
        st_next.awready = !st_next.aw_have && !st_next.bvalid;
        st_next.wready  = !st_next.w_have && !st_next.bvalid;

        // read channel; upper bits of every register read as zero
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid  = 1'b1;
            st_next.rresp   = supervision_timer_pkg::RESP_OKAY;
            st_next.rdata   = 32'h0000_0000;
            unique case (s_axi_araddr)
                supervision_timer_pkg::CTRL_ADDR: begin
                    st_next.rdata[3:0] = {st_reg.mode, st_reg.sel};
                end
                supervision_timer_pkg::STATUS_ADDR: begin
                    st_next.rdata[1:0] = st_reg.status;
                end
                supervision_timer_pkg::ENABLE_ADDR: begin
                    st_next.rdata[1:0] = st_reg.enable;
                end
                supervision_timer_pkg::CLEAR_ADDR: begin
                    st_next.rdata = 32'h0000_0000;
                end
                default: begin
                    st_next.rresp = supervision_timer_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid  = 1'b0;
            st_next.arready = 1'b1;
        end

        // boot strap passes two flops, then loads the select field once
        st_next.boot_s1 = boot_timeout_select;
        st_next.boot_s2 = st_reg.boot_s1;
        if (!boot_done) begin
            st_next.boot_cnt = st_reg.boot_cnt + 2'h1;
            if (st_reg.boot_cnt == supervision_timer_pkg::BOOT_WAIT - 2'h1) begin
                st_next.sel = st_reg.boot_s2;
            end
        end else if (cfg_wr) begin
            // software rewrite after boot load
            st_next.sel  = st_reg.wdata[supervision_timer_pkg::SEL_MSB:
                                        supervision_timer_pkg::SEL_LSB];
            st_next.mode = st_reg.wdata[supervision_timer_pkg::MODE_BIT];
        end

        // periodic mode counts freely; interrupt mode counts only while ext_irq_pending or its own irq is high
        counting = boot_done && !st_reg.shutdown
                   && (st_reg.sel != supervision_timer_pkg::SEL_DISABLED)
                   && (!st_reg.mode || st_reg.irq || ext_irq_pending);

        // seconds prescaler and seconds counter
        if (!counting || cfg_wr) begin
            st_next.presc = 32'h0000_0000;
            st_next.sec   = 7'h00;
        end else if (st_reg.presc == CYCLES_PER_SECOND - 32'h1) begin
            st_next.presc = 32'h0000_0000;
            if (st_reg.sec == limit - 7'h1) begin
                st_next.sec = 7'h00;
                expire      = 1'b1;
            end else begin
                st_next.sec = st_reg.sec + 7'h1;
            end
        end else begin
            st_next.presc = st_reg.presc + 32'h1;
        end

        // expiry: tick in periodic mode, shutdown when the last tick was missed or at once in interrupt mode
        if (expire) begin
            if (st_reg.mode) begin
                ev_set[supervision_timer_pkg::EV_SHUTDOWN] = 1'b1;
            end else begin
                ev_set[supervision_timer_pkg::EV_TICK] = 1'b1;
                if (st_reg.status[supervision_timer_pkg::EV_TICK]
                    && !clr_mask[supervision_timer_pkg::EV_TICK]) begin
                    ev_set[supervision_timer_pkg::EV_SHUTDOWN] = 1'b1;
                end
            end
        end
        if (ev_set[supervision_timer_pkg::EV_SHUTDOWN]) begin
            st_next.shutdown = 1'b1;
        end

        // sticky status: a set in the same cycle as its clear wins
        st_next.status = (st_reg.status & ~clr_mask) | ev_set;
        st_next.irq    = |(st_next.status & st_next.enable);
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg          <= '0;
            st_reg.mode     <= supervision_timer_pkg::MODE_RESET;
            st_reg.sel      <= supervision_timer_pkg::SEL_RESET;
            st_reg.enable   <= supervision_timer_pkg::ENABLE_RESET;
            st_reg.awready  <= 1'b1;
            st_reg.wready   <= 1'b1;
            st_reg.arready  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready              = st_reg.awready;
    assign s_axi_wready               = st_reg.wready;
    assign s_axi_bvalid               = st_reg.bvalid;
    assign s_axi_bresp                = st_reg.bresp;
    assign s_axi_arready              = st_reg.arready;
    assign s_axi_rvalid               = st_reg.rvalid;
    assign s_axi_rresp                = st_reg.rresp;
    assign s_axi_rdata                = st_reg.rdata;
    assign irq                        = st_reg.irq;
    assign supervision_timer_shutdown = st_reg.shutdown;

    // ==========================================================
    // assertions
    property p_disabled_idle;
        @(posedge clk) disable iff (rst)
        (st_reg.sel == supervision_timer_pkg::SEL_DISABLED) |-> !expire && !counting;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle)
        else $error("timer ran with select code zero");

    property p_decode;
        @(posedge clk) disable iff (rst)
        (st_reg.sel == 3'h3) |-> (limit == 7'h14);
    endproperty
    a_decode: assert property (p_decode)
        else $error("select code three is not twenty seconds");

    property p_tick_set;
        @(posedge clk) disable iff (rst)
        (expire && !st_reg.mode) |=> st_reg.status[supervision_timer_pkg::EV_TICK];
    endproperty
    a_tick_set: assert property (p_tick_set)
        else $error("periodic expiry did not raise the tick");

    property p_missed_tick;
        @(posedge clk) disable iff (rst)
        (expire && !st_reg.mode && st_reg.status[supervision_timer_pkg::EV_TICK]
         && !clr_mask[supervision_timer_pkg::EV_TICK]) |=> st_reg.shutdown;
    endproperty
    a_missed_tick: assert property (p_missed_tick)
        else $error("missed tick did not force shutdown");

    property p_cleared_tick;
        @(posedge clk) disable iff (rst)
        (expire && !st_reg.mode && !st_reg.status[supervision_timer_pkg::EV_TICK]
         && !st_reg.shutdown) |=> !st_reg.shutdown;
    endproperty
    a_cleared_tick: assert property (p_cleared_tick)
        else $error("shutdown although tick was cleared");

    property p_irq_mode;
        @(posedge clk) disable iff (rst)
        (expire && st_reg.mode) |=> st_reg.shutdown
            && st_reg.status[supervision_timer_pkg::EV_SHUTDOWN];
    endproperty
    a_irq_mode: assert property (p_irq_mode)
        else $error("pending timeout did not force shutdown");

    property p_boot_load;
        @(posedge clk) disable iff (rst)
        $rose(boot_done) |-> (st_reg.sel == $past(boot_timeout_select, 3)) && !st_reg.mode;
    endproperty
    a_boot_load: assert property (p_boot_load)
        else $error("boot value not loaded into select field");

    property p_ctrl_upper_zero;
        @(posedge clk) disable iff (rst)
        (s_axi_arvalid && st_reg.arready && s_axi_araddr == supervision_timer_pkg::CTRL_ADDR)
        |=> s_axi_rvalid && (s_axi_rdata[31:4] == 28'h0);
    endproperty
    a_ctrl_upper_zero: assert property (p_ctrl_upper_zero)
        else $error("control upper bits not zero");

    property p_restart;
        @(posedge clk) disable iff (rst)
        (cfg_wr || !counting) |=> (st_reg.presc == 32'h0) && (st_reg.sec == 7'h00);
    endproperty
    a_restart: assert property (p_restart)
        else $error("count did not restart");

    property p_shutdown_sticky;
        @(posedge clk) disable iff (rst)
        st_reg.shutdown |=> st_reg.shutdown [*2];
    endproperty
    a_shutdown_sticky: assert property (p_shutdown_sticky)
        else $error("shutdown dropped before reset");

    c_tick: cover property (@(posedge clk) disable iff (rst) expire && !st_reg.mode);
    c_missed: cover property (@(posedge clk) disable iff (rst)
        $rose(st_reg.shutdown) && !st_reg.mode);
    c_irq_mode: cover property (@(posedge clk) disable iff (rst)
        $rose(st_reg.shutdown) && st_reg.mode);
    c_write: cover property (@(posedge clk) disable iff (rst) do_write && cfg_wr);

endmodule

// ---- src/supervision_timer_pkg.sv ----
/*
 * constants shared by the supervision timer: register map, field layout,
 * reset values, timeout decode and timing counts.
 * assumes a 200 MHz system clock and a 32-bit axi4-lite register bus.
 */
package supervision_timer_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ            = 200_000_000;
    localparam int unsigned TICK_S            = 1;      // counting unit, in seconds
    localparam int unsigned CYCLES_PER_SECOND = CLK_HZ * TICK_S;

    // ==========================================================
    // register map (byte addresses, 12-bit decode)
    localparam logic [11:0] CTRL_INDEX   = 12'h069;    // printed offset, word index
    localparam logic [11:0] CTRL_ADDR    = 12'h1a4;    // four times the index
    localparam logic [11:0] STATUS_ADDR  = 12'h200;    // sticky events, read only
    localparam logic [11:0] CLEAR_ADDR   = 12'h204;    // write one to clear
    localparam logic [11:0] ENABLE_ADDR  = 12'h208;    // interrupt enable

    // ==========================================================
    // control register fields
    localparam int unsigned SEL_LSB      = 0;
    localparam int unsigned SEL_MSB      = 2;
    localparam int unsigned MODE_BIT     = 3;
    localparam logic [2:0]  SEL_DISABLED = 3'h0;
    localparam logic        MODE_RESET   = 1'h0;       // periodic operation
    localparam logic [2:0]  SEL_RESET    = 3'h0;       // until the boot value lands

    // status / clear / enable bit positions
    localparam int unsigned EV_TICK      = 0;          // periodic interrupt
    localparam int unsigned EV_SHUTDOWN  = 1;          // shutdown was forced
    localparam logic [1:0]  ENABLE_RESET = 2'h0;

    // ==========================================================
    // axi responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // edges after reset release until the select field holds the boot value:
    // two synchroniser stages, then one edge to load from the second stage
    localparam logic [1:0]  BOOT_WAIT    = 2'h3;

    // timeout in seconds for each select code
    function automatic logic [6:0] timeout_secs(input logic [2:0] sel);
        unique case (sel)
            3'h1:    timeout_secs = 7'h05;
            3'h2:    timeout_secs = 7'h0a;
            3'h3:    timeout_secs = 7'h14;
            3'h4:    timeout_secs = 7'h28;
            3'h5:    timeout_secs = 7'h3c;
            3'h6:    timeout_secs = 7'h50;
            3'h7:    timeout_secs = 7'h64;
            default: timeout_secs = 7'h00;
        endcase
    endfunction

endpackage
